// ===== src/pwr_halt_cfg.svh
`ifndef PWR_HALT_CFG_SVH
`define PWR_HALT_CFG_SVH
`define PMC2_ADDR 12'h000
`define MHC1_ADDR 12'h004
`define PMC2_MASK 8'hbc
`define MHC1_MASK 8'h3e
`define PMC2_RSVD 8'h43
`define MHC1_RSVD 8'hc1
`define PMC2_RESET 8'h00
`define MHC1_RESET 8'h00
`define BIT_VARIANT 7
`define BIT_DIRECT 5
`define DIV_LSB 2
`define DIV_MSB 4
`define BIT_SER 5
`define BIT_ADC 4
`define BIT_WDT 3
`define BIT_TMR2 2
`define BIT_TMR1 1
`endif

// ===== src/pwr_halt_pkg.sv
package pwr_halt_pkg;
  typedef enum logic [2:0] {MODE_ACTIVE, MODE_SLEEP, MODE_SUBSLEEP, MODE_STANDBY, MODE_DIRECT} sleep_target_t;
  typedef logic [7:0] reg8_t;
endpackage

// ===== src/ctrl_reg8.sv
`timescale 1ns/100ps
// ****************************************
// Masked 8-bit control register
// ****************************************
module ctrl_reg8
  import pwr_halt_pkg::*;
#(
  parameter logic [7:0] MASK = 8'hff,
  parameter logic [7:0] RESET = 8'h00
)
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic wr_i,
  input wire logic [7:0] wdata_i,
  output reg8_t q_o
);
  // Reserved positions never load
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      q_o <= RESET & MASK;
    else if (wr_i)
      q_o <= wdata_i & MASK;
  end
endmodule

// ===== src/clk_div_sel.sv
`timescale 1ns/100ps
// ****************************************
// Divider code to ratio decode
// ****************************************
module clk_div_sel
(
  input wire logic [2:0] code_i,
  output logic [6:0] ratio_o
);
  // Top bit low means undivided
  always_comb
  begin
    unique case (code_i)
      3'h4: ratio_o = 7'h08;
      3'h5: ratio_o = 7'h10;
      3'h6: ratio_o = 7'h20;
      3'h7: ratio_o = 7'h40;
      default: ratio_o = 7'h01;
    endcase
  end
endmodule

// ===== src/power_mode_and_module_halt_ctrl.sv
// Design decisions made here: the address map and the APB register port.
`timescale 1ns/100ps
`include "pwr_halt_cfg.svh"
// ****************************************
// Register map
// ****************************************
// Word at offset 0x000: power mode control
//   Bit 7: sleep variant select
//   Bit 6: reserved, reads zero
//   Bit 5: direct switch flag
//   Bits 4 to 2: active clock divider
//   Bits 1 and 0: reserved, read zero
// Word at offset 0x004: module halt control
//   Bits 7 and 6: reserved, read zero
//   Bit 5: serial port halt
//   Bit 4: converter halt
//   Bit 3: watchdog halt
//   Bit 2: second timer halt
//   Bit 1: first timer halt
//   Bit 0: reserved, reads zero
// ****************************************
// Bus behaviour
// ****************************************
//   Zero wait states, ready tied high
//   Writes need byte lane 0 strobed
//   Unmapped words answer with an error
//   Read data latched in the setup cycle
//   Only the low byte of a word is live
// ****************************************
// Sleep behaviour
// ****************************************
//   Target follows register and standby input
//   Divider reaches the clock only at sleep
//   Mode change pulse one cycle after sleep
// ****************************************
// Power mode and module halt control
// ****************************************
module power_mode_and_module_halt_ctrl
  import pwr_halt_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic deep_halt_select_i,
  input wire logic sleep_exec_i,
  input wire logic wdt_int_osc_i,
  output logic [6:0] active_div_ratio_o,
  output sleep_target_t sleep_target_o,
  output logic mode_change_o,
  output logic serial_port_halt_o,
  output logic adc_halt_o,
  output logic wdt_halt_o,
  output logic second_timer_halt_o,
  output logic first_timer_halt_o
);
  // ****************************************
  // Elaboration check
  // ****************************************
  if (ADDR_W < 3 || ADDR_W > 12)
  begin : g_bad
    $error("ADDR_W must be 3 to 12");
  end

  // Two registers need distinct words
  if (`PMC2_ADDR == `MHC1_ADDR)
  begin : g_bad_map
    $error("register offsets must differ");
  end

  // Reserved power mode bits must stay masked
  if ((`PMC2_MASK & `PMC2_RSVD) != 8'h00)
  begin : g_bad_pmc_mask
    $error("power mode mask covers reserved bits");
  end

  // Reserved halt bits must stay masked
  if ((`MHC1_MASK & `MHC1_RSVD) != 8'h00)
  begin : g_bad_mhc_mask
    $error("halt mask covers reserved bits");
  end

  // Offsets must fit the address port
  if (ADDR_W < 12 && (`MHC1_ADDR >> ADDR_W) != 0)
  begin : g_bad_reach
    $error("halt register beyond address range");
  end

  // ****************************************
  // APB decode
  // ****************************************
  logic wr_en;
  logic hit_pmc;
  logic hit_mhc;
  logic [11:0] addr12;
  reg8_t pmc_q;
  reg8_t mhc_q;
  logic [2:0] div_applied_q;
  logic [6:0] ratio;
  sleep_target_t target;
  logic [31:0] prdata_d;
  logic pslverr_d;
  logic [31:0] prdata_q;
  logic pslverr_q;
  // Per-register write strobes
  logic wr_pmc;
  logic wr_mhc;
  // Named field views of the stored bits
  logic sleep_variant_select;
  logic direct_switch_flag;
  logic active_clock_divider_msb;
  logic active_clock_divider_mid;
  logic active_clock_divider_lsb;
  logic [2:0] div_pending;
  logic serial_port_halt;
  logic adc_halt;
  logic wdt_halt;
  logic second_timer_halt;
  logic first_timer_halt;
  logic wdt_gate;

  // Zero-answer bus: always ready in the access phase
  assign addr12 = 12'(paddr_i);
  assign hit_pmc = (addr12 == `PMC2_ADDR);
  assign hit_mhc = (addr12 == `MHC1_ADDR);
  // Only byte lane 0 carries data; a write without it is dropped
  assign wr_en = psel_i && penable_i && pwrite_i && pstrb_i[0];
  assign pready_o = 1'b1;

  // ****************************************
  // Write strobes
  // ****************************************
  // One strobe per register, never both
  always_comb
  begin
    wr_pmc = 1'b0;
    wr_mhc = 1'b0;
    if (wr_en)
    begin
      if (hit_pmc)
        wr_pmc = 1'b1;
      else if (hit_mhc)
        wr_mhc = 1'b1;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  ctrl_reg8 #(.MASK(`PMC2_MASK), .RESET(`PMC2_RESET)) u_pmc (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .wr_i(wr_pmc),
    .wdata_i(pwdata_i[7:0]),
    .q_o(pmc_q)
  );

  ctrl_reg8 #(.MASK(`MHC1_MASK), .RESET(`MHC1_RESET)) u_mhc (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .wr_i(wr_mhc),
    .wdata_i(pwdata_i[7:0]),
    .q_o(mhc_q)
  );

  // ****************************************
  // Field views
  // ****************************************
  // Power mode fields by name
  assign sleep_variant_select = pmc_q[`BIT_VARIANT];
  assign direct_switch_flag = pmc_q[`BIT_DIRECT];
  // Divider as written, not yet applied
  assign active_clock_divider_msb = pmc_q[`DIV_MSB];
  assign active_clock_divider_mid = pmc_q[`DIV_LSB + 1];
  assign active_clock_divider_lsb = pmc_q[`DIV_LSB];
  assign div_pending = {active_clock_divider_msb, active_clock_divider_mid, active_clock_divider_lsb};

  // Halt fields by name
  assign serial_port_halt = mhc_q[`BIT_SER];
  assign adc_halt = mhc_q[`BIT_ADC];
  assign wdt_halt = mhc_q[`BIT_WDT];
  assign second_timer_halt = mhc_q[`BIT_TMR2];
  assign first_timer_halt = mhc_q[`BIT_TMR1];

  // ****************************************
  // Read path
  // ****************************************
  // Reserved bits already zero in storage
  always_comb
  begin
    prdata_d = 32'h0000_0000;
    pslverr_d = 1'b0;
    if (hit_pmc)
      prdata_d = {24'h000000, pmc_q};
    else if (hit_mhc)
      prdata_d = {24'h000000, mhc_q};
    else
      pslverr_d = 1'b1;
  end

  // Read data registered in the setup cycle
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end
    else if (psel_i && !penable_i)
    begin
      prdata_q <= pwrite_i ? 32'h0000_0000 : prdata_d;
      pslverr_q <= pslverr_d;
    end
  end

  assign prdata_o = prdata_q;
  assign pslverr_o = pslverr_q && psel_i && penable_i;

  // ****************************************
  // Sleep target selection
  // ****************************************
  // Direct flag outranks standby select
  // Standby select outranks the variant bit
  // Variant bit picks subsleep over light sleep
  // Purely combinational; sampled by the core at sleep
  always_comb
  begin
    if (direct_switch_flag)
      target = MODE_DIRECT;
    else if (deep_halt_select_i)
      target = MODE_STANDBY;
    else if (sleep_variant_select)
      target = MODE_SUBSLEEP;
    else
      target = MODE_SLEEP;
  end

  assign sleep_target_o = target;

  // ****************************************
  // Divider, applied only at sleep
  // ****************************************
  // Running clock must not glitch on a plain write
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      div_applied_q <= 3'h0;
    else if (sleep_exec_i)
      div_applied_q <= div_pending;
  end

  // Pulse one cycle after sleep is taken
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      mode_change_o <= 1'b0;
    else
      mode_change_o <= sleep_exec_i;
  end

  clk_div_sel u_div (
    .code_i(div_applied_q),
    .ratio_o(ratio)
  );

  assign active_div_ratio_o = ratio;

  // ****************************************
  // Module halt outputs
  // ****************************************
  // Straight from storage, high means halted
  assign serial_port_halt_o = serial_port_halt;
  assign adc_halt_o = adc_halt;
  // Internal oscillator keeps watchdog alive
  // Stored bit is kept, only its effect is masked
  assign wdt_gate = !wdt_int_osc_i;
  assign wdt_halt_o = wdt_halt && wdt_gate;
  assign second_timer_halt_o = second_timer_halt;
  assign first_timer_halt_o = first_timer_halt;
endmodule

// ===== tb/pmh_checker_assertions.sv
`timescale 1ns/100ps
`include "pwr_halt_cfg.svh"
// ****************************************
// Port checker for power mode and halt control
// ****************************************
module pmh_checker
  import pwr_halt_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  input wire logic [31:0] prdata_o,
  input wire logic pslverr_o,
  input wire logic deep_halt_select_i,
  input wire logic sleep_exec_i,
  input wire logic wdt_int_osc_i,
  input wire logic [6:0] active_div_ratio_o,
  input wire sleep_target_t sleep_target_o,
  input wire logic mode_change_o,
  input wire logic serial_port_halt_o,
  input wire logic adc_halt_o,
  input wire logic wdt_halt_o,
  input wire logic second_timer_halt_o,
  input wire logic first_timer_halt_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // Access phase qualifier
  wire logic acc = psel_i && penable_i;
  wire logic hwr = acc && pwrite_i && pstrb_i[0] && paddr_i == `MHC1_ADDR;
  // ****************************************
  // Assertions
  // ****************************************
  rsvd_pmc_a: assert property (acc && !pwrite_i && paddr_i == `PMC2_ADDR |-> (prdata_o & 32'hffffff43) == 0)
    else $error("power mode reserved bits set");
  rsvd_mhc_a: assert property (acc && !pwrite_i && paddr_i == `MHC1_ADDR |-> (prdata_o & 32'hffffffc1) == 0)
    else $error("halt reserved bits set");
  halt_write_a: assert property (hwr |=> {serial_port_halt_o, adc_halt_o, second_timer_halt_o,
    first_timer_halt_o} == {$past(pwdata_i[5:4]), $past(pwdata_i[2:1])}) else $error("halt outputs wrong");
  wdt_osc_a: assert property (wdt_int_osc_i |-> !wdt_halt_o) else $error("watchdog halted on osc");
  div_hold_a: assert property ($changed(active_div_ratio_o) |-> $past(sleep_exec_i) || $past(sleep_exec_i, 2))
    else $error("ratio changed without sleep");
  ratio_set_a: assert property (active_div_ratio_o inside {7'h01, 7'h08, 7'h10, 7'h20, 7'h40})
    else $error("illegal ratio");
  mode_pulse_a: assert property (sleep_exec_i |=> mode_change_o) else $error("no mode change pulse");
  standby_sel_a: assert property (deep_halt_select_i && sleep_target_o != MODE_DIRECT
    |-> sleep_target_o == MODE_STANDBY) else $error("standby not chosen");
  err_map_a: assert property (acc |-> pslverr_o == !(paddr_i inside {`PMC2_ADDR, `MHC1_ADDR}))
    else $error("error response wrong");
  // Main scenarios
  cover property (sleep_exec_i && deep_halt_select_i);
  cover property (acc && pslverr_o);
  cover property (hwr && wdt_int_osc_i);
endmodule
bind power_mode_and_module_halt_ctrl pmh_checker #(.ADDR_W(ADDR_W)) pmh_checker_i (.*);

// ===== tb/tb.sv
`timescale 1ns/100ps
module tb
  import pwr_halt_pkg::*;
;
  logic core_clk_i, rst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, err;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, rd;
  logic [3:0] pstrb_i;
  logic deep_halt_select_i, sleep_exec_i, wdt_int_osc_i, mode_change_o;
  logic serial_port_halt_o, adc_halt_o, wdt_halt_o, second_timer_halt_o, first_timer_halt_o;
  logic [6:0] active_div_ratio_o, ratio;
  sleep_target_t sleep_target_o, tgt;
  int mismatches, check_count;
  power_mode_and_module_halt_ctrl power_mode_and_module_halt_ctrl_i (.*);
  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask
  // One APB transfer, then an idle cycle
  task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    psel_i <= 1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= {24'h0, d};
    @(posedge core_clk_i);
    penable_i <= 1;
    n = 0;
    do
    begin
      @(posedge core_clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 50);
    if (n >= 50)
      mismatches++;
    chk("ready", pready_o, 1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 0;
    penable_i <= 0;
    @(posedge core_clk_i);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Clock, 4 ns period
  initial
  begin
    core_clk_i = 0;
    forever #2 core_clk_i = ~core_clk_i;
  end
  // Watchdog against a hang
  initial
  begin
    #20000;
    mismatches++;
    results();
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    {rst_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = {1'b1, 47'h0};
    {pstrb_i, deep_halt_select_i, sleep_exec_i, wdt_int_osc_i} = 7'h78;
    repeat (4) @(posedge core_clk_i);
    rst_i <= 0;
    @(posedge core_clk_i);
    xfer(0, 12'h000, 8'h00); chk("pmc rst", rd, 0);
    xfer(0, 12'h004, 8'h00); chk("mhc rst", rd, 0);
    xfer(1, 12'h004, 8'hff); xfer(0, 12'h004, 8'h00); chk("mhc ff", rd, 32'h3e);
    chk("halts", {serial_port_halt_o, adc_halt_o, wdt_halt_o, second_timer_halt_o, first_timer_halt_o}, 5'h1f);
    wdt_int_osc_i <= 1;
    @(posedge core_clk_i); chk("wdt osc", wdt_halt_o, 0);
    pstrb_i <= 0;
    xfer(1, 12'h004, 8'h00); xfer(0, 12'h004, 8'h00); chk("no strb", rd, 32'h3e);
    pstrb_i <= 4'hf;
    xfer(1, 12'h008, 8'hff); chk("unmap err", err, 1);
    xfer(0, 12'h008, 8'h00); chk("unmap rd err", err, 1);
    chk("unmap rd", rd, 0);
    ratio = 1;
    for (int i = 0; i < 8; i++)
    begin
      deep_halt_select_i <= i[1];
      xfer(1, 12'h000, {i[2], 1'b0, i[0], i[2:0], 2'b11});
      xfer(0, 12'h000, 8'h00); chk("pmc rd", rd, {i[2], 1'b0, i[0], i[2:0], 2'b00});
      chk("ratio held", active_div_ratio_o, ratio);
      tgt = i[0] ? MODE_DIRECT : i[1] ? MODE_STANDBY : i[2] ? MODE_SUBSLEEP : MODE_SLEEP;
      chk("target", sleep_target_o, tgt);
      sleep_exec_i <= 1;
      @(posedge core_clk_i);
      sleep_exec_i <= 0;
      #1 chk("mode pulse", mode_change_o, 1);
      @(posedge core_clk_i);
      #1 chk("mode end", mode_change_o, 0);
      @(posedge core_clk_i);
      ratio = i[2] ? 7'h08 << i[1:0] : 7'h01;
      chk("ratio new", active_div_ratio_o, ratio);
    end
    results();
  end
endmodule
